//--- rtl/excd_pkg.sv
/*
 * Shared constants of the exception cause detector: register map,
 * field positions, reset values, vector offsets and instruction kinds.
 * Assumes a 32-bit APB slave with byte addresses in a 256-byte window.
 */
package excd_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_MSR = 8'h00;
    localparam logic [7:0] ADDR_FP_STATUS_CONTROL_REG = 8'h04;
    localparam logic [7:0] ADDR_DCNT = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_LAST = 8'h14;
    // ==========================================================
    // Machine state fields
    localparam int MSR_PR = 0;
    localparam int MSR_FP = 1;
    localparam int MSR_FE0 = 2;
    localparam int MSR_FE1 = 3;
    localparam logic [3:0] MSR_RESET = 4'h0;
    localparam int FP_STATUS_CONTROL_REG_FEX = 0;
    localparam logic [31:0] DCNT_RESET = 32'h0000_0000;
    // ==========================================================
    // Status / mask bits, one per exception taken
    localparam int ST_EXT = 0;
    localparam int ST_ALIGN = 1;
    localparam int ST_PROG = 2;
    localparam int ST_FPUN = 3;
    localparam int ST_DEC = 4;
    localparam logic [4:0] MASK_RESET = 5'h00;
    // ==========================================================
    // Program exception cause bits
    localparam int CAUSE_FPE = 0;
    localparam int CAUSE_ILL = 1;
    localparam int CAUSE_PRIV = 2;
    localparam int CAUSE_TRAP = 3;
    // ==========================================================
    // Vector offsets
    localparam logic [19:0] VEC_NONE = 20'h00000;
    localparam logic [19:0] VEC_EXT = 20'h00500;
    localparam logic [19:0] VEC_ALIGN = 20'h00600;
    localparam logic [19:0] VEC_PROG = 20'h00700;
    localparam logic [19:0] VEC_FPUN = 20'h00800;
    localparam logic [19:0] VEC_DEC = 20'h00900;
    // ==========================================================
    // Instruction kinds presented by the completion stage
    typedef enum logic [3:0]
    {
        KIND_OTHER,
        KIND_FP_LS,
        KIND_LOAD_MULTI,
        KIND_STORE_MULTI,
        KIND_LOAD_RSV,
        KIND_STORE_COND,
        KIND_BLK_ZERO,
        KIND_EXT_IN,
        KIND_EXT_OUT
    } excd_kind_t;
endpackage

//--- rtl/excd_top.sv
/*
 * Exception cause detector: decides which exception the core takes,
 * and at which vector, for the instruction at completion, the external
 * interrupt pin and the down counter. Registers sit on APB.
 * Assumes the pipeline presents the oldest completing instruction with
 * its decoded attributes on the core clock, and flushes on O_EXC_TAKE.
 */
`timescale 1ns/1ps
module excd_top
(
    input wire logic I_REF_CLK,
    input wire logic I_RST_B,
    input wire logic I_INT,
    input wire logic I_INSN_VALID,
    input wire excd_pkg::excd_kind_t I_INSN_KIND,
    input wire logic [1:0] I_EA_LOW,
    input wire logic I_FP_INSN,
    input wire logic I_PAGE_CI,
    input wire logic I_PAGE_WT,
    input wire logic I_DC_LOCKED,
    input wire logic I_DC_DISABLED,
    input wire logic I_ILLEGAL_OP,
    input wire logic I_PRIV_OP,
    input wire logic I_SPR_INVALID,
    input wire logic I_SPR_BIT0,
    input wire logic I_TRAP_HIT,
    input wire logic I_FP_ENABLED_EXC,
    input wire logic I_MOVE_TO_FP_STATUS_CONTROL_REG,
    input wire logic [7:0] I_FP_STATUS_CONTROL_REG_EXC,
    input wire logic [7:0] I_FP_STATUS_CONTROL_REG_EN,
    input wire logic I_ALL_DONE,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic O_EXC_TAKE,
    output logic [19:0] O_EXC_VECTOR,
    output logic [3:0] O_CAUSE,
    output logic O_DISPATCH_STALL,
    output logic O_IRQ
);
    typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_WAIT} excd_state_t;

    function automatic logic unaligned(input logic [1:0] ea);
        unaligned = ea != 2'h0;
    endfunction

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] b);
        hit = a == b;
    endfunction

    // ==========================================================
    // Interrupt pin synchroniser
    logic int_meta;
    logic int_s;
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RST_B)
        begin
            int_meta <= 1'b0;
            int_s <= 1'b0;
        end
        else
        begin
            int_meta <= I_INT;
            int_s <= int_meta;
        end
    end

    // ==========================================================
    // Software state
    logic [3:0] machine_state_reg;
    logic fp_enabled_summary;
    logic [31:0] down_counter;
    logic dcnt_msb_q;
    logic dec_pend;
    logic [4:0] status;
    logic [4:0] mask;
    excd_state_t state;
    excd_state_t next_state;
    // Cause and vector of the last exception taken, kept for software
    logic [23:0] last_taken;

    wire msr_pr = machine_state_reg[excd_pkg::MSR_PR];
    wire msr_fp = machine_state_reg[excd_pkg::MSR_FP];
    wire fe_any = machine_state_reg[excd_pkg::MSR_FE0]
                | machine_state_reg[excd_pkg::MSR_FE1];

    // ==========================================================
    // Instruction exception decode
    wire k_fpls = I_INSN_KIND == excd_pkg::KIND_FP_LS;
    wire k_zero = I_INSN_KIND == excd_pkg::KIND_BLK_ZERO;
    wire k_word = k_fpls
                | I_INSN_KIND == excd_pkg::KIND_LOAD_MULTI
                | I_INSN_KIND == excd_pkg::KIND_STORE_MULTI
                | I_INSN_KIND == excd_pkg::KIND_LOAD_RSV
                | I_INSN_KIND == excd_pkg::KIND_STORE_COND;
    wire k_extc = I_INSN_KIND == excd_pkg::KIND_EXT_IN
                | I_INSN_KIND == excd_pkg::KIND_EXT_OUT;
    wire c_align = (k_word & unaligned(I_EA_LOW))
                 | (k_zero & (I_PAGE_CI | I_PAGE_WT))
                 | (k_zero & (I_DC_LOCKED | I_DC_DISABLED))
                 | (k_extc & unaligned(I_EA_LOW));
    wire c_ill = I_ILLEGAL_OP;
    wire c_priv = msr_pr & (I_PRIV_OP
                | (I_SPR_INVALID & I_SPR_BIT0));
    wire c_trap = I_TRAP_HIT;
    wire c_fpun = (I_FP_INSN | k_fpls) & ~msr_fp;
    wire fex_set = I_INSN_VALID & (I_FP_ENABLED_EXC
                 | (I_MOVE_TO_FP_STATUS_CONTROL_REG & |(I_FP_STATUS_CONTROL_REG_EXC & I_FP_STATUS_CONTROL_REG_EN)));
    // Mode bits both clear means enabled exceptions are ignored
    wire c_fpe = fex_set & fe_any;
    wire c_prog = c_ill | c_priv | c_trap | c_fpe;
    wire insn_exc = I_INSN_VALID & (c_prog | c_align | c_fpun);
    // The completing instruction is older than any asynchronous event
    wire take_ext = state == ST_DRAIN & I_ALL_DONE & ~insn_exc;
    wire take_dec = state == ST_RUN & dec_pend & ~insn_exc & ~int_s;
    wire take_any = insn_exc | take_ext | take_dec;

    // Fixed order: illegal, privileged, unavailable, alignment, trap, fp
    logic [19:0] next_vector;
    assign next_vector = !take_any ? excd_pkg::VEC_NONE
        : !insn_exc ? (take_ext ? excd_pkg::VEC_EXT
                                : excd_pkg::VEC_DEC)
        : (c_ill | c_priv) ? excd_pkg::VEC_PROG
        : c_fpun ? excd_pkg::VEC_FPUN
        : c_align ? excd_pkg::VEC_ALIGN
        : excd_pkg::VEC_PROG;
    wire prog_sel = insn_exc & next_vector == excd_pkg::VEC_PROG;
    wire [3:0] next_cause = prog_sel
        ? {c_trap, c_priv, c_ill, c_fpe} : 4'h0;

    // ==========================================================
    // External interrupt sequencing
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_RUN: if (int_s) next_state = ST_DRAIN;
            ST_DRAIN: if (take_ext) next_state = ST_WAIT;
            // Source keeps the pin up into the handler; do not retake
            ST_WAIT: if (!int_s) next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RST_B)
        begin
            state <= ST_RUN;
            O_DISPATCH_STALL <= 1'b0;
            O_EXC_TAKE <= 1'b0;
            O_EXC_VECTOR <= excd_pkg::VEC_NONE;
            O_CAUSE <= 4'h0;
            last_taken <= 24'h00_0000;
        end
        else
        begin
            state <= next_state;
            if (take_any)
                last_taken <= {next_cause, next_vector};
            O_DISPATCH_STALL <= next_state == ST_DRAIN;
            O_EXC_TAKE <= take_any;
            O_EXC_VECTOR <= next_vector;
            O_CAUSE <= next_cause;
        end
    end

    // ==========================================================
    // APB slave: one wait state, write and read at the ready edge
    wire acc = I_PSEL & I_PENABLE & O_PREADY;
    wire wr = acc & I_PWRITE;
    wire w_msr = wr & hit(I_PADDR, excd_pkg::ADDR_MSR);
    wire w_fp_status_control_reg = wr & hit(I_PADDR, excd_pkg::ADDR_FP_STATUS_CONTROL_REG);
    wire w_dcnt = wr & hit(I_PADDR, excd_pkg::ADDR_DCNT);
    wire w_stat = wr & hit(I_PADDR, excd_pkg::ADDR_STATUS);
    wire w_mask = wr & hit(I_PADDR, excd_pkg::ADDR_MASK);
    wire mapped = hit(I_PADDR, excd_pkg::ADDR_MSR)
                | hit(I_PADDR, excd_pkg::ADDR_FP_STATUS_CONTROL_REG)
                | hit(I_PADDR, excd_pkg::ADDR_DCNT)
                | hit(I_PADDR, excd_pkg::ADDR_STATUS)
                | hit(I_PADDR, excd_pkg::ADDR_MASK)
                | hit(I_PADDR, excd_pkg::ADDR_LAST);
    wire [31:0] rd_mux =
          hit(I_PADDR, excd_pkg::ADDR_MSR) ? {28'h0, machine_state_reg}
        : hit(I_PADDR, excd_pkg::ADDR_FP_STATUS_CONTROL_REG) ? {31'h0, fp_enabled_summary}
        : hit(I_PADDR, excd_pkg::ADDR_DCNT) ? down_counter
        : hit(I_PADDR, excd_pkg::ADDR_STATUS) ? {27'h0, status}
        : hit(I_PADDR, excd_pkg::ADDR_MASK) ? {27'h0, mask}
        : hit(I_PADDR, excd_pkg::ADDR_LAST) ? {8'h0, last_taken}
        : 32'h0;
    wire next_ready = I_PSEL & I_PENABLE & ~O_PREADY;

    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RST_B)
        begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA <= 32'h0;
        end
        else
        begin
            O_PREADY <= next_ready;
            O_PSLVERR <= next_ready & ~mapped;
            O_PRDATA <= (next_ready & ~I_PWRITE) ? rd_mux : 32'h0;
        end
    end

    // ==========================================================
    // Machine state, summary bit, down counter
    wire dcnt_rise = ~dcnt_msb_q & down_counter[31];
    // Set beats a write-one clear in the same cycle
    wire next_fex = fex_set
        | (fp_enabled_summary & ~(w_fp_status_control_reg & I_PWDATA[excd_pkg::FP_STATUS_CONTROL_REG_FEX]));
    wire next_dec_pend = dcnt_rise | (dec_pend & ~take_dec);

    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RST_B)
        begin
            machine_state_reg <= excd_pkg::MSR_RESET;
            fp_enabled_summary <= 1'b0;
            down_counter <= excd_pkg::DCNT_RESET;
            dcnt_msb_q <= 1'b0;
            dec_pend <= 1'b0;
        end
        else
        begin
            if (w_msr)
                machine_state_reg <= I_PWDATA[3:0];
            fp_enabled_summary <= next_fex;
            down_counter <= w_dcnt ? I_PWDATA : down_counter - 32'h1;
            dcnt_msb_q <= down_counter[31];
            dec_pend <= next_dec_pend;
        end
    end

    // ==========================================================
    // Sticky status, mask, interrupt line
    wire [4:0] ev;
    assign ev[excd_pkg::ST_EXT] = take_ext;
    assign ev[excd_pkg::ST_ALIGN] = insn_exc
        & next_vector == excd_pkg::VEC_ALIGN;
    assign ev[excd_pkg::ST_PROG] = prog_sel;
    assign ev[excd_pkg::ST_FPUN] = insn_exc
        & next_vector == excd_pkg::VEC_FPUN;
    assign ev[excd_pkg::ST_DEC] = take_dec;
    wire [4:0] next_status = ev | (status & ~(w_stat ? I_PWDATA[4:0] : 5'h0));

    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RST_B)
        begin
            status <= 5'h0;
            mask <= excd_pkg::MASK_RESET;
            O_IRQ <= 1'b0;
        end
        else
        begin
            status <= next_status;
            if (w_mask)
                mask <= I_PWDATA[4:0];
            O_IRQ <= |(next_status & mask);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B);

    property p_ext_vec;
        take_ext |=> O_EXC_TAKE && O_EXC_VECTOR == excd_pkg::VEC_EXT;
    endproperty
    a_ext_vec: assert property (p_ext_vec)
        else $error("external interrupt not taken at its vector");

    property p_drain;
        state == ST_DRAIN && !take_ext |=> O_DISPATCH_STALL;
    endproperty
    a_drain: assert property (p_drain)
        else $error("dispatch not stalled while draining");

    property p_ext_done;
        O_EXC_TAKE && O_EXC_VECTOR == excd_pkg::VEC_EXT
            |-> $past(I_ALL_DONE) && $past(state) == ST_DRAIN;
    endproperty
    a_ext_done: assert property (p_ext_done)
        else $error("external interrupt taken before drain");

    property p_older_first;
        insn_exc |=> O_EXC_TAKE && O_EXC_VECTOR != excd_pkg::VEC_EXT
            && O_EXC_VECTOR != excd_pkg::VEC_DEC;
    endproperty
    a_older_first: assert property (p_older_first)
        else $error("asynchronous exception beat an instruction");

    property p_align;
        I_INSN_VALID && k_word && I_EA_LOW != 2'h0 && !c_ill && !c_priv
            && !c_fpun |=> O_EXC_VECTOR == excd_pkg::VEC_ALIGN;
    endproperty
    a_align: assert property (p_align)
        else $error("unaligned access missed alignment vector");

    property p_prog_cause;
        O_EXC_TAKE && O_EXC_VECTOR == excd_pkg::VEC_PROG |-> O_CAUSE != 4'h0;
    endproperty
    a_prog_cause: assert property (p_prog_cause)
        else $error("program exception without cause");

    property p_fex;
        fex_set |=> fp_enabled_summary;
    endproperty
    a_fex: assert property (p_fex)
        else $error("enabled summary not set");

    property p_priv;
        I_INSN_VALID && msr_pr && I_PRIV_OP && !I_ILLEGAL_OP |=>
            O_EXC_VECTOR == excd_pkg::VEC_PROG && O_CAUSE[excd_pkg::CAUSE_PRIV];
    endproperty
    a_priv: assert property (p_priv)
        else $error("privileged op in user mode not trapped");

    property p_fpun;
        I_INSN_VALID && I_FP_INSN && !msr_fp && !c_ill && !c_priv
            |=> O_EXC_VECTOR == excd_pkg::VEC_FPUN;
    endproperty
    a_fpun: assert property (p_fpun)
        else $error("fp unavailable not raised");

    property p_dec;
        dcnt_rise |=> dec_pend ##[0:40] O_EXC_VECTOR == excd_pkg::VEC_DEC
            || state != ST_RUN || O_EXC_TAKE;
    endproperty
    a_dec: assert property (p_dec)
        else $error("counter msb rise not pended");
endmodule

//--- tb/excd_int_src.sv
/*
 * Model of the external interrupt source that drives the core's pin.
 * Assumes the core clock and the taken-exception outputs of the core.
 */
`timescale 1ns/1ps
module excd_int_src
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_req,
    input wire logic i_take,
    input wire logic [19:0] i_vector,
    output logic o_int
);
    // ==========================================================
    // Request level
    // Held until the handler starts, so a long drain never loses it
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            o_int <= 1'b0;
        else if (i_take && i_vector == excd_pkg::VEC_EXT)
            o_int <= 1'b0;
        else if (i_req)
            o_int <= 1'b1;
    end
endmodule

//--- tb/exception_cause_detect_tb.sv
/*
 * Self-checking bench of the exception cause detector.
 * Assumes excd_top with its APB slave and the interrupt source model.
 */
`timescale 1ns/1ps
module exception_cause_detect_tb;
    // ==========================================================
    // Signals
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req = 1'b0;
    logic int_pin;
    logic valid = 1'b0;
    excd_pkg::excd_kind_t kind = excd_pkg::KIND_OTHER;
    logic [1:0] ea = 2'h0;
    logic [11:0] fl = 12'h000;
    logic all_done = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, take, stall, irq, err;
    logic [19:0] vec;
    logic [3:0] cause;
    logic [31:0] rd;
    int n_mismatch = 0;
    int check_count = 0;
    int n;

    always #4 clk = ~clk;

    // ==========================================================
    // Design and interrupt source
    // Move flag drives overlapping exception and enable bits
    excd_top i_dut
    (
        .I_REF_CLK(clk), .I_RST_B(rst_b), .I_INT(int_pin),
        .I_INSN_VALID(valid), .I_INSN_KIND(kind), .I_EA_LOW(ea),
        .I_FP_INSN(fl[0]), .I_PAGE_CI(fl[1]), .I_PAGE_WT(fl[2]),
        .I_DC_LOCKED(fl[3]), .I_DC_DISABLED(fl[4]),
        .I_ILLEGAL_OP(fl[5]), .I_PRIV_OP(fl[6]), .I_SPR_INVALID(fl[7]),
        .I_SPR_BIT0(fl[8]), .I_TRAP_HIT(fl[9]),
        .I_FP_ENABLED_EXC(fl[10]), .I_MOVE_TO_FP_STATUS_CONTROL_REG(fl[11]),
        .I_FP_STATUS_CONTROL_REG_EXC({8{fl[11]}} & 8'h24),
        .I_FP_STATUS_CONTROL_REG_EN({8{fl[11]}} & 8'h0C), .I_ALL_DONE(all_done),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .O_EXC_TAKE(take),
        .O_EXC_VECTOR(vec), .O_CAUSE(cause),
        .O_DISPATCH_STALL(stall), .O_IRQ(irq)
    );

    excd_int_src i_src
    (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_req(req),
        .i_take(take), .i_vector(vec), .o_int(int_pin)
    );

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Values read here are those sampled at this rising edge
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One instruction at completion, then the taken exception is judged
    task automatic insn(input excd_pkg::excd_kind_t k, input logic [1:0] a,
                        input logic [11:0] f, input logic [19:0] ev,
                        input logic [3:0] ec);
        @(posedge clk);
        valid <= 1'b1;
        kind <= k;
        ea <= a;
        fl <= f;
        @(posedge clk);
        valid <= 1'b0;
        ea <= 2'h0;
        fl <= 12'h000;
        #1;
        check("take", 32'(take), 32'(ev != excd_pkg::VEC_NONE));
        check("vector", 32'(vec), 32'(ev));
        check("cause", 32'(cause), 32'(ec));
    endtask

    task automatic wait_take();
        #1;
        for (n = 0; n < 20 && take !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        apb(1'b0, excd_pkg::ADDR_MSR, 32'h0);
        check("msr", rd, 32'(excd_pkg::MSR_RESET));
        apb(1'b0, excd_pkg::ADDR_MASK, 32'h0);
        check("mask", rd, 32'(excd_pkg::MASK_RESET));
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
    endtask

    task automatic t_program();
        apb(1'b1, excd_pkg::ADDR_MSR, 32'h3);
        insn(excd_pkg::KIND_OTHER, 2'h0, 12'h020, excd_pkg::VEC_PROG, 4'h2);
        apb(1'b0, excd_pkg::ADDR_LAST, 32'h0);
        check("last", rd, 32'h0020_0700);
        insn(excd_pkg::KIND_OTHER, 2'h0, 12'h040, excd_pkg::VEC_PROG, 4'h4);
        insn(excd_pkg::KIND_OTHER, 2'h0, 12'h180, excd_pkg::VEC_PROG, 4'h4);
        insn(excd_pkg::KIND_OTHER, 2'h0, 12'h200, excd_pkg::VEC_PROG, 4'h8);
        insn(excd_pkg::KIND_FP_LS, 2'h1, 12'h201, excd_pkg::VEC_ALIGN, 4'h0);
        apb(1'b1, excd_pkg::ADDR_MSR, 32'h0);
        insn(excd_pkg::KIND_OTHER, 2'h0, 12'h040, excd_pkg::VEC_NONE, 4'h0);
        insn(excd_pkg::KIND_OTHER, 2'h0, 12'h021, excd_pkg::VEC_PROG, 4'h2);
        insn(excd_pkg::KIND_FP_LS, 2'h0, 12'h001, excd_pkg::VEC_FPUN, 4'h0);
    endtask

    task automatic t_align();
        excd_pkg::excd_kind_t ks[7] = '{excd_pkg::KIND_FP_LS,
            excd_pkg::KIND_LOAD_MULTI, excd_pkg::KIND_STORE_MULTI,
            excd_pkg::KIND_LOAD_RSV, excd_pkg::KIND_STORE_COND,
            excd_pkg::KIND_EXT_IN, excd_pkg::KIND_EXT_OUT};
        apb(1'b1, excd_pkg::ADDR_MSR, 32'h2);
        foreach (ks[i])
            insn(ks[i], 2'h2, 12'h001, excd_pkg::VEC_ALIGN, 4'h0);
        insn(excd_pkg::KIND_LOAD_MULTI, 2'h0, 12'h000, excd_pkg::VEC_NONE, 4'h0);
        for (int b = 1; b < 5; b++)
            insn(excd_pkg::KIND_BLK_ZERO, 2'h0, 12'(1 << b), excd_pkg::VEC_ALIGN, 4'h0);
        insn(excd_pkg::KIND_BLK_ZERO, 2'h0, 12'h000, excd_pkg::VEC_NONE, 4'h0);
    endtask

    task automatic t_fpe();
        insn(excd_pkg::KIND_OTHER, 2'h0, 12'h401, excd_pkg::VEC_NONE, 4'h0);
        apb(1'b1, excd_pkg::ADDR_FP_STATUS_CONTROL_REG, 32'h1);
        apb(1'b1, excd_pkg::ADDR_MSR, 32'h6);
        insn(excd_pkg::KIND_OTHER, 2'h0, 12'h401, excd_pkg::VEC_PROG, 4'h1);
        apb(1'b0, excd_pkg::ADDR_FP_STATUS_CONTROL_REG, 32'h0);
        check("summary", rd, 32'h1);
        apb(1'b1, excd_pkg::ADDR_FP_STATUS_CONTROL_REG, 32'h1);
        apb(1'b0, excd_pkg::ADDR_FP_STATUS_CONTROL_REG, 32'h0);
        check("summary clear", rd, 32'h0);
        insn(excd_pkg::KIND_OTHER, 2'h0, 12'h801, excd_pkg::VEC_PROG, 4'h1);
    endtask

    task automatic t_int();
        @(posedge clk);
        all_done <= 1'b0;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        #1;
        for (n = 0; n < 10 && stall !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        check("stall", 32'(stall), 32'h1);
        repeat (4) @(posedge clk);
        #1;
        check("no take", 32'(take), 32'h0);
        insn(excd_pkg::KIND_OTHER, 2'h0, 12'h020, excd_pkg::VEC_PROG, 4'h2);
        @(posedge clk);
        all_done <= 1'b1;
        wait_take();
        check("int vector", 32'(vec), 32'(excd_pkg::VEC_EXT));
        @(posedge clk);
        #1;
        check("stall off", 32'(stall), 32'h0);
    endtask

    task automatic t_dec();
        apb(1'b1, excd_pkg::ADDR_STATUS, 32'h1F);
        apb(1'b1, excd_pkg::ADDR_MASK, 32'h10);
        apb(1'b1, excd_pkg::ADDR_DCNT, 32'h3);
        wait_take();
        check("dec vector", 32'(vec), 32'(excd_pkg::VEC_DEC));
        apb(1'b0, excd_pkg::ADDR_STATUS, 32'h0);
        check("status", rd & 32'h10, 32'h10);
        #1;
        check("irq on", 32'(irq), 32'h1);
        apb(1'b1, excd_pkg::ADDR_STATUS, 32'h10);
        @(posedge clk);
        #1;
        check("irq off", 32'(irq), 32'h0);
    endtask

    // ==========================================================
    // Sequence and watchdog
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_program();
        t_align();
        t_fpe();
        t_int();
        t_dec();
        tally_and_finish();
    end

    initial
    begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
